// file: core/tcc_timer16.sv
// Purpose: 16-bit timer/counter with input capture on an 8-bit I/O port
// Assumes: CPU keeps 16-bit byte pairs atomic, high write first
// Notes: Read data appear one clock after the read strobe
`timescale 1ns/10ps
module tcc_timer16 (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // CPU I/O port
  input wire logic [tcc_pkg::TCC_AW-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Pins
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_out,
  // Interrupt requests and service acknowledges
  output logic overflow_irq,
  output logic capture_irq,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  // Counter status
  output logic count_peak,
  output logic count_floor
);
  import tcc_pkg::*;

  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Registers
  logic [7:0] timer_ctrl_a;
  logic [7:0] timer_ctrl_b;
  logic [7:0] irq_en;
  logic [7:0] comparator_ctrl_status;
  logic [15:0] count_value;
  logic [15:0] capture_value;
  logic [7:0] temp_byte;
  logic overflow_flag;
  logic capture_flag;
  tcc_dir_t dir;
  logic [7:0] next_ctrl_a;
  logic [7:0] next_ctrl_b;
  logic [7:0] next_irq_en;
  logic [7:0] next_cmp_ctl;
  logic [15:0] next_count;
  logic [15:0] next_capture;
  logic [7:0] next_temp;
  logic next_ovf;
  logic next_cap_flag;
  tcc_dir_t next_dir;
  logic [7:0] next_rdata;

  // Decoded strobes
  wire logic wr_cnt_lo = io_wr && (io_addr == TCC_ADDR_CNT_LO);
  wire logic wr_cnt_hi = io_wr && (io_addr == TCC_ADDR_CNT_HI);
  wire logic rd_cnt_lo = io_rd && (io_addr == TCC_ADDR_CNT_LO);
  wire logic wr_cap_lo = io_wr && (io_addr == TCC_ADDR_CAP_LO);
  wire logic wr_cap_hi = io_wr && (io_addr == TCC_ADDR_CAP_HI);
  wire logic rd_cap_lo = io_rd && (io_addr == TCC_ADDR_CAP_LO);
  wire logic wr_flags = io_wr && (io_addr == TCC_ADDR_FLAGS);

  // Mode decode
  logic [3:0] waveform_mode_sel;
  logic [2:0] clock_source_select;
  logic filter_enable;
  logic edge_rising;
  logic comparator_trigger_sel;
  logic [15:0] top_val;
  logic dual_slope;
  logic cap_is_top;
  logic ovf_at_top;

  assign waveform_mode_sel = {timer_ctrl_b[TCC_CTLB_WGM_LSB +: 2],
                              timer_ctrl_a[TCC_CTLA_WGM_LSB +: 2]}; // R10
  assign clock_source_select = timer_ctrl_b[TCC_CTLB_CS_LSB +: 3];
  assign filter_enable = timer_ctrl_b[TCC_CTLB_FILT_BIT]; // R20
  assign edge_rising = timer_ctrl_b[TCC_CTLB_EDGE_BIT]; // R26
  assign comparator_trigger_sel = comparator_ctrl_status[TCC_CMP_TRIG_BIT];

  always_comb begin
    top_val = TCC_MAX;
    dual_slope = 1'b0;
    cap_is_top = 1'b0;
    ovf_at_top = 1'b0;
    case (waveform_mode_sel) // R10
      4'h1: begin
        top_val = TCC_TOP_8BIT;
        dual_slope = 1'b1;
      end
      4'h2: begin
        top_val = TCC_TOP_9BIT;
        dual_slope = 1'b1;
      end
      4'h3: begin
        top_val = TCC_TOP_10BIT;
        dual_slope = 1'b1;
      end
      4'h5: begin
        top_val = TCC_TOP_8BIT;
        ovf_at_top = 1'b1;
      end
      4'h6: begin
        top_val = TCC_TOP_9BIT;
        ovf_at_top = 1'b1;
      end
      4'h7: begin
        top_val = TCC_TOP_10BIT;
        ovf_at_top = 1'b1;
      end
      4'h8, 4'ha: begin
        top_val = capture_value;
        dual_slope = 1'b1;
        cap_is_top = 1'b1;
      end
      4'h9, 4'hb: dual_slope = 1'b1;
      4'hc: begin
        top_val = capture_value;
        cap_is_top = 1'b1;
      end
      4'he: begin
        top_val = capture_value;
        cap_is_top = 1'b1;
        ovf_at_top = 1'b1;
      end
      4'hf: ovf_at_top = 1'b1;
      default: top_val = TCC_MAX;
    endcase
  end

  // Synchronisers and tick source
  logic ext_level;
  logic pin_level;
  logic cmp_level;
  logic timer_tick;

  tcc_sync3 u_sync_ext (
    .clk(clk),
    .rst_n(rst_n),
    .din(ext_count_pin),
    .level(ext_level)
  );
  tcc_sync3 u_sync_pin (
    .clk(clk),
    .rst_n(rst_n),
    .din(capture_pin),
    .level(pin_level)
  ); // R18 R22
  tcc_sync3 u_sync_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .din(comparator_out),
    .level(cmp_level)
  ); // R18
  tcc_prescale u_prescale (
    .clk(clk),
    .rst_n(rst_n),
    .clock_source_select(clock_source_select),
    .ext_level(ext_level),
    .timer_tick(timer_tick)
  ); // R7

  // Counter and overflow
  logic ovf_evt;

  always_comb begin
    next_count = count_value;
    next_dir = dir;
    ovf_evt = 1'b0;
    if (wr_cnt_lo) begin
      next_count = {temp_byte, io_wdata}; // R3 R8 R9
    end else if (timer_tick) begin
      if (dual_slope) begin
        if (dir == TCC_DIR_UP && count_value >= top_val) begin
          next_dir = TCC_DIR_DOWN;
          next_count = count_value - 16'h0001; // R5
        end else if (dir == TCC_DIR_DOWN && count_value == TCC_FLOOR) begin
          next_dir = TCC_DIR_UP;
          next_count = count_value + 16'h0001; // R5
          ovf_evt = 1'b1; // R11
        end else if (dir == TCC_DIR_UP) begin
          next_count = count_value + 16'h0001;
        end else begin
          next_count = count_value - 16'h0001;
        end
      end else begin
        next_dir = TCC_DIR_UP;
        if (count_value == top_val) begin
          next_count = TCC_FLOOR; // R5
        end else begin
          next_count = count_value + 16'h0001;
        end
        ovf_evt = ovf_at_top ? (count_value == top_val)
                             : (count_value == TCC_MAX); // R11
      end
    end
    next_ovf = (overflow_flag && !overflow_irq_ack &&
                !(wr_flags && io_wdata[TCC_FLAG_OVF_BIT])) || ovf_evt;
  end
  assign count_peak = (count_value == top_val); // R6
  assign count_floor = (count_value == TCC_FLOOR); // R6 R25
  assign overflow_irq = overflow_flag && irq_en[TCC_FLAG_OVF_BIT]; // R11
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= TCC_RST_WORD;
      dir <= TCC_DIR_UP;
      overflow_flag <= 1'b0;
    end else begin
      count_value <= next_count;
      dir <= next_dir;
      overflow_flag <= next_ovf;
    end
  end

  // Noise filter, edge detector and capture
  logic trig_level;
  logic [TCC_FILT_N-1:0] samples;
  logic [TCC_FILT_N-1:0] next_samples;
  logic filt_level;
  logic next_filt;
  logic edge_in;
  logic edge_prev;
  logic capture_evt;
  assign trig_level = comparator_trigger_sel ? cmp_level : pin_level; // R17
  always_comb begin
    next_samples = {samples[TCC_FILT_N-2:0], trig_level};
    next_filt = filt_level;
    if (&samples) begin
      next_filt = 1'b1; // R19
    end else if (~|samples) begin
      next_filt = 1'b0; // R19
    end
    edge_in = filter_enable ? filt_level : trig_level; // R20
    capture_evt = !cap_is_top &&
                  (edge_rising ? (edge_in && !edge_prev)
                               : (!edge_in && edge_prev)); // R21 R26
    next_capture = capture_value;
    if (capture_evt) begin
      next_capture = count_value; // R12
    end else if (wr_cap_lo && cap_is_top) begin
      next_capture = {temp_byte, io_wdata}; // R16
    end
    next_cap_flag = (capture_flag && !capture_irq_ack &&
                     !(wr_flags && io_wdata[TCC_FLAG_CAP_BIT])) ||
                    capture_evt; // R13 R14
  end
  assign capture_irq = capture_flag && irq_en[TCC_FLAG_CAP_BIT]; // R13
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samples <= '0;
      filt_level <= 1'b0;
      edge_prev <= 1'b0;
      capture_value <= TCC_RST_WORD;
      capture_flag <= 1'b0;
    end else begin
      samples <= next_samples;
      filt_level <= next_filt;
      edge_prev <= edge_in;
      capture_value <= next_capture;
      capture_flag <= next_cap_flag;
    end
  end

  // Staging byte, control registers and read data
  always_comb begin
    next_temp = temp_byte;
    if (wr_cnt_hi || wr_cap_hi) begin
      next_temp = io_wdata; // R2 R24
    end else if (rd_cnt_lo) begin
      next_temp = count_value[15:8]; // R3
    end else if (rd_cap_lo) begin
      next_temp = capture_value[15:8]; // R15
    end
    next_ctrl_a = timer_ctrl_a;
    next_ctrl_b = timer_ctrl_b;
    next_irq_en = irq_en;
    next_cmp_ctl = comparator_ctrl_status;
    if (io_wr) begin
      unique case (io_addr)
        TCC_ADDR_CTRL_A: next_ctrl_a = io_wdata;
        TCC_ADDR_CTRL_B: next_ctrl_b = io_wdata;
        TCC_ADDR_IRQ_EN: next_irq_en = io_wdata;
        TCC_ADDR_CMP_CTL: next_cmp_ctl = io_wdata;
        default: next_ctrl_a = timer_ctrl_a;
      endcase
    end
    next_rdata = io_rdata;
    if (io_rd) begin
      unique case (io_addr)
        TCC_ADDR_CTRL_A: next_rdata = timer_ctrl_a;
        TCC_ADDR_CTRL_B: next_rdata = timer_ctrl_b;
        TCC_ADDR_CNT_LO: next_rdata = count_value[7:0]; // R1
        TCC_ADDR_CNT_HI: next_rdata = temp_byte; // R1 R2
        TCC_ADDR_CAP_LO: next_rdata = capture_value[7:0];
        TCC_ADDR_CAP_HI: next_rdata = temp_byte; // R15
        TCC_ADDR_FLAGS: begin
          next_rdata = TCC_RST_BYTE;
          next_rdata[TCC_FLAG_OVF_BIT] = overflow_flag;
          next_rdata[TCC_FLAG_CAP_BIT] = capture_flag;
        end
        TCC_ADDR_IRQ_EN: next_rdata = irq_en;
        TCC_ADDR_CMP_CTL: next_rdata = comparator_ctrl_status;
        default: next_rdata = TCC_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_byte <= TCC_RST_BYTE;
      timer_ctrl_a <= TCC_RST_BYTE;
      timer_ctrl_b <= TCC_RST_BYTE;
      irq_en <= TCC_RST_BYTE;
      comparator_ctrl_status <= TCC_RST_BYTE;
      io_rdata <= TCC_RST_BYTE;
    end else begin
      temp_byte <= next_temp;
      timer_ctrl_a <= next_ctrl_a;
      timer_ctrl_b <= next_ctrl_b;
      irq_en <= next_irq_en;
      comparator_ctrl_status <= next_cmp_ctl;
      io_rdata <= next_rdata;
    end
  end
endmodule

// file: pkg/tcc_pkg.sv
// Purpose: Constants and types shared by the 16-bit timer with capture
// Assumes: 8-bit CPU I/O port, one 125 MHz system clock
// Notes on behaviour
// R1 - Counter is seen as two byte locations, upper and lower eight bits.
// R2 - Any access to a high-byte location reaches the shared staging byte.
// R3 - Low read saves upper byte to staging; low write takes upper from it.
// R4 - Software may write staging once for several registers, uninterrupted.
// R5 - Each timer tick counts up, down or clears as mode and direction say.
// R6 - Peak indication at sequence top, floor indication at zero.
// R7 - Three-bit clock source select; zero stops the counter.
// R8 - Counter stays readable and writable with or without a timer tick.
// R9 - A CPU counter write beats any clear or count in that cycle.
// R10 - Four-bit waveform mode over both control registers sets the sequence.
// R11 - Overflow flag set where the mode says; it can request an interrupt.
// R12 - A matching edge on pin or comparator copies the count to capture.
// R13 - Capture flag set with the copy; enabled flag raises an interrupt.
// R14 - Capture flag clears on interrupt service or on writing a one.
// R15 - Capture low read copies high byte to staging; high read returns it.
// R16 - Capture accepts writes only in modes using it as peak.
// R17 - Trigger select routes comparator to capture; clear the flag after.
// R18 - Capture inputs are synchronised and edge-detected like the count pin.
// R19 - Filter moves only after four equal samples; feeds edge detector.
// R20 - Filter enable bit in control B; four-cycle delay on system clock; the code delays edges by five cycles.
// R21 - Filter and edge inputs active except in modes using capture as peak.
// R22 - Software driving the capture pin captures like an outside event.
// R23 - Software writes high before low, reads low before high.
// R24 - One staging byte is shared by all 16-bit registers of the timer.
// R25 - Floor is count 0x0000, maximum count is 0xffff.
// R26 - A configuration bit selects rising or falling capture edges.
package tcc_pkg;
  // I/O port map
  localparam int unsigned TCC_AW = 4;
  localparam logic [3:0] TCC_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] TCC_ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] TCC_ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] TCC_ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] TCC_ADDR_CAP_LO = 4'h4;
  localparam logic [3:0] TCC_ADDR_CAP_HI = 4'h5;
  localparam logic [3:0] TCC_ADDR_FLAGS = 4'h6;
  localparam logic [3:0] TCC_ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] TCC_ADDR_CMP_CTL = 4'h8;
  // Reset values
  localparam logic [7:0] TCC_RST_BYTE = 8'h00;
  localparam logic [15:0] TCC_RST_WORD = 16'h0000;
  // Field positions
  localparam int unsigned TCC_CTLA_WGM_LSB = 0;
  localparam int unsigned TCC_CTLB_CS_LSB = 0;
  localparam int unsigned TCC_CTLB_WGM_LSB = 3;
  localparam int unsigned TCC_CTLB_EDGE_BIT = 6;
  localparam int unsigned TCC_CTLB_FILT_BIT = 7;
  localparam int unsigned TCC_FLAG_OVF_BIT = 0;
  localparam int unsigned TCC_FLAG_CAP_BIT = 5;
  localparam int unsigned TCC_CMP_TRIG_BIT = 2;
  // Counter limits
  localparam logic [15:0] TCC_FLOOR = 16'h0000;
  localparam logic [15:0] TCC_MAX = 16'hffff;
  localparam logic [15:0] TCC_TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TCC_TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TCC_TOP_10BIT = 16'h03ff;
  // Clock source select codes
  localparam logic [2:0] TCC_CS_STOP = 3'h0;
  localparam logic [2:0] TCC_CS_DIV1 = 3'h1;
  localparam logic [2:0] TCC_CS_DIV8 = 3'h2;
  localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TCC_CS_DIV256 = 3'h4;
  localparam logic [2:0] TCC_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;
  // Prescaler masks: tick when all masked bits are ones
  localparam int unsigned TCC_PRE_W = 10;
  localparam logic [9:0] TCC_PRE_M8 = 10'h007;
  localparam logic [9:0] TCC_PRE_M64 = 10'h03f;
  localparam logic [9:0] TCC_PRE_M256 = 10'h0ff;
  localparam logic [9:0] TCC_PRE_M1024 = 10'h3ff;
  // Noise filter length in system clocks
  localparam int unsigned TCC_FILT_N = 4;
  // Count direction
  typedef enum logic {TCC_DIR_UP, TCC_DIR_DOWN} tcc_dir_t;
endpackage

// file: core/tcc_sync3.sv
// Purpose: Three-stage synchroniser for a pin level
// Assumes: Input is asynchronous to clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
module tcc_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic din,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb begin
    next_level = (s2 == s3) ? s3 : level; // R18
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule

// file: core/tcc_prescale.sv
// Purpose: Timer tick from system clock divider or count pin edges
// Assumes: ext_level already synchronised
// Notes: Divider runs freely; stop code gives no tick
`timescale 1ns/10ps
module tcc_prescale (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [2:0] clock_source_select,
  input wire logic ext_level,
  // Tick out
  output logic timer_tick
);
  import tcc_pkg::*;
  logic [TCC_PRE_W-1:0] pre;
  logic [TCC_PRE_W-1:0] next_pre;
  logic ext_prev;

  always_comb begin
    next_pre = pre + 10'h001;
    unique case (clock_source_select) // R7
      TCC_CS_STOP: timer_tick = 1'b0;
      TCC_CS_DIV1: timer_tick = 1'b1;
      TCC_CS_DIV8: timer_tick = (pre & TCC_PRE_M8) == TCC_PRE_M8;
      TCC_CS_DIV64: timer_tick = (pre & TCC_PRE_M64) == TCC_PRE_M64;
      TCC_CS_DIV256: timer_tick = (pre & TCC_PRE_M256) == TCC_PRE_M256;
      TCC_CS_DIV1024: timer_tick = (pre & TCC_PRE_M1024) == TCC_PRE_M1024;
      TCC_CS_EXT_FALL: timer_tick = ext_prev && !ext_level;
      TCC_CS_EXT_RISE: timer_tick = !ext_prev && ext_level;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= '0;
      ext_prev <= 1'b0;
    end else begin
      pre <= next_pre;
      ext_prev <= ext_level;
    end
  end
endmodule

// file: testbench/tcc_timer16_properties.sv
// Purpose: Port-level checks of the 16-bit timer with capture
// Assumes: Strobes are one-cycle pulses with idle cycles between
// Notes: Sees only top module ports
`timescale 1ns/10ps
module tcc_timer16_properties
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // CPU port
  input wire logic [TCC_AW-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Interrupts and status
  input wire logic overflow_irq,
  input wire logic capture_irq,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  input wire logic count_peak,
  input wire logic count_floor
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic flag_wr;
  assign flag_wr = io_wr && io_addr == TCC_ADDR_FLAGS;
  sequence hi_zero;
    io_wr && io_addr == TCC_ADDR_CNT_HI && io_wdata == 8'h00;
  endsequence
  sequence lo_zero;
    io_wr && io_addr == TCC_ADDR_CNT_LO && io_wdata == 8'h00;
  endsequence
  sequence idle;
    !io_wr && !io_rd;
  endsequence
  read_data_hold_a: assert property (
    $changed(io_rdata) |-> $past(io_rd)) else $error("rdata moved");
  unmapped_zero_a: assert property (
    io_rd && io_addr > TCC_ADDR_CMP_CTL |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_state_a: assert property (
    $rose(reset_n) |-> count_floor && !count_peak && !capture_irq)
    else $error("bad state after reset");
  floor_write_a: assert property (
    hi_zero ##1 idle ##1 lo_zero |=> count_floor)
    else $error("floor missing after zero write");
  ovf_clear_a: assert property (
    flag_wr && io_wdata[0] && !count_peak && !count_floor
    |=> !overflow_irq) else $error("overflow flag not cleared");
  ovf_ack_clear_a: assert property (
    overflow_irq_ack && !count_peak && !count_floor |=> !overflow_irq)
    else $error("overflow ack did not clear");
  cap_clear_a: assert property (
    flag_wr && io_wdata[5] |=> !capture_irq)
    else $error("capture flag not cleared");
  cap_ack_clear_a: assert property (
    capture_irq_ack |=> !capture_irq) else $error("capture ack failed");
  irq_off_a: assert property (
    io_wr && io_addr == TCC_ADDR_IRQ_EN && io_wdata == 8'h00
    |=> !overflow_irq && !capture_irq) else $error("irq not masked");
endmodule
bind tcc_timer16 tcc_timer16_properties chk (.*);

// file: testbench/tcc_cpu_model.sv
// Purpose: CPU side of the 8-bit I/O port
// Assumes: Requests driven at the falling edge, one idle cycle after
// Notes: Write data lines show inverted value when idle
`timescale 1ns/10ps
module tcc_cpu_model (
  // Clock
  input wire logic clk,
  // I/O port
  output logic [tcc_pkg::TCC_AW-1:0] io_addr = '0,
  output logic io_rd = 1'b0,
  output logic io_wr = 1'b0,
  output logic [7:0] io_wdata = 8'h00,
  input wire logic [7:0] io_rdata,
  // Interrupt service
  output logic overflow_irq_ack = 1'b0,
  output logic capture_irq_ack = 1'b0
);
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  // High byte first on write, low byte first on read
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask
  task automatic svc(input logic cap);
    @(negedge clk);
    if (cap) capture_irq_ack = 1'b1;
    else overflow_irq_ack = 1'b1;
    @(negedge clk);
    capture_irq_ack = 1'b0;
    overflow_irq_ack = 1'b0;
  endtask
endmodule

// file: testbench/counter16_with_input_capture_bench.sv
// Purpose: Self-checking bench of the 16-bit timer with capture
// Assumes: Counter stopped whenever exact values are compared
// Notes: Model keeps staging byte, count and capture as integers
`timescale 1ns/10ps
module counter16_with_input_capture_bench;
  import tcc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ext_count_pin = 1'b0;
  logic capture_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic [3:0] io_addr;
  logic io_rd, io_wr, overflow_irq_ack, capture_irq_ack;
  logic [7:0] io_wdata, io_rdata;
  logic overflow_irq, capture_irq, count_peak, count_floor;
  int n_fail = 0;
  int n_checks = 0;
  int stg = 0;
  int m_cnt = 0;
  int m_cap = 0;
  logic [31:0] lf = 32'h00012d48;
  logic [15:0] v;
  logic [7:0] b;
  int m;
  always #4 clk = ~clk;
  tcc_timer16 dut (.*);
  tcc_cpu_model cpu (.*);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd();
    lf = lfsr(lf);
    v = lf[15:0];
  endtask
  task automatic set_cnt(input logic [15:0] x);
    cpu.wr16(TCC_ADDR_CNT_LO, x);
    stg = x[15:8];
    m_cnt = x;
  endtask
  task automatic rd_cmp(input logic [3:0] lo, input int e);
    cpu.rd16(lo, v);
    stg = v[15:8];
    chk("word", e[15:0], v);
  endtask
  task automatic wait_hi(input logic cap, input int lim);
    int i;
    for (i = 0; i < lim && ((cap ? capture_irq : overflow_irq) !== 1'b1); i++)
      @(posedge clk);
    if (i == lim) begin
      $display("FAIL irq wait expected 1 seen 0");
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic cap_flag(input logic e);
    repeat (30) @(posedge clk);
    cpu.rd8(TCC_ADDR_FLAGS, b);
    chk("capture flag", {15'h0, e}, {15'h0, b[5]});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    $display("FAIL run length expected end seen timeout");
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset floor", 16'h1, {15'h0, count_floor});
    chk("reset peak", 16'h0, {15'h0, count_peak});
    cpu.wr8(TCC_ADDR_IRQ_EN, 8'h21);
    set_cnt(16'h0000);
    for (int i = 0; i < 4; i++) begin
      rnd();
      set_cnt(v);
      rd_cmp(TCC_ADDR_CNT_LO, m_cnt);
    end
    cpu.rd8(4'hf, b);
    chk("unmapped", 16'h0, {8'h0, b});
    for (int e = 1; e >= 0; e--) begin
      cpu.wr8(TCC_ADDR_CTRL_B, e[0] ? 8'h40 : 8'h00);
      rnd();
      set_cnt(v);
      capture_pin = e[0];
      wait_hi(1'b1, 100);
      m_cap = m_cnt;
      rd_cmp(TCC_ADDR_CAP_LO, m_cap);
      if (e) cpu.svc(1'b1);
      else cpu.wr8(TCC_ADDR_FLAGS, 8'h20);
      chk("cap irq clear", 16'h0, {15'h0, capture_irq});
    end
    cpu.wr8(TCC_ADDR_CNT_HI, 8'h5a);
    stg = 8'h5a;
    cpu.rd8(TCC_ADDR_CAP_LO, b);
    stg = m_cap[15:8];
    cpu.wr8(TCC_ADDR_CNT_LO, 8'h11);
    m_cnt = {stg[7:0], 8'h11};
    rd_cmp(TCC_ADDR_CNT_LO, m_cnt);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h40);
    cpu.wr8(TCC_ADDR_CMP_CTL, 8'h04);
    repeat (30) @(posedge clk);
    cpu.wr8(TCC_ADDR_FLAGS, 8'h20);
    comparator_out = 1'b1;
    wait_hi(1'b1, 100);
    m_cap = m_cnt;
    rd_cmp(TCC_ADDR_CAP_LO, m_cap);
    cpu.wr8(TCC_ADDR_CMP_CTL, 8'h00);
    repeat (30) @(posedge clk);
    cpu.wr8(TCC_ADDR_FLAGS, 8'h20);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'hc0);
    @(negedge clk) capture_pin = 1'b1;
    repeat (2) @(negedge clk);
    capture_pin = 1'b0;
    cap_flag(1'b0);
    capture_pin = 1'b1;
    wait_hi(1'b1, 100);
    cpu.wr8(TCC_ADDR_FLAGS, 8'h20);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h40);
    cpu.wr16(TCC_ADDR_CAP_LO, 16'h1234);
    rd_cmp(TCC_ADDR_CAP_LO, m_cap);
    cpu.wr8(TCC_ADDR_CTRL_A, 8'h02);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h58);
    cpu.wr16(TCC_ADDR_CAP_LO, 16'h0100);
    m_cap = 16'h0100;
    rd_cmp(TCC_ADDR_CAP_LO, m_cap);
    set_cnt(16'h0100);
    chk("cap top peak", 16'h1, {15'h0, count_peak});
    capture_pin = 1'b0;
    repeat (10) @(negedge clk);
    capture_pin = 1'b1;
    cap_flag(1'b0);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h40);
    for (m = 0; m < 8; m++) begin
      if (m == 4) continue;
      cpu.wr8(TCC_ADDR_CTRL_A, {6'h0, m[1:0]});
      cpu.wr8(TCC_ADDR_CTRL_B, {3'h2, m[3:2], 3'h0});
      v = m[1:0] == 2'h0 ? 16'hffff : 16'h00ff >> 0;
      if (m[1:0] == 2'h2) v = 16'h01ff;
      if (m[1:0] == 2'h3) v = 16'h03ff;
      set_cnt(v);
      chk("peak at top", 16'h1, {15'h0, count_peak});
      set_cnt(v - 16'h1);
      chk("no peak", 16'h0, {15'h0, count_peak});
    end
    cpu.wr8(TCC_ADDR_CTRL_A, 8'h00);
    set_cnt(16'h0000);
    chk("floor", 16'h1, {15'h0, count_floor});
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h07);
    repeat (5) begin
      repeat (6) @(negedge clk);
      ext_count_pin = 1'b1;
      repeat (6) @(negedge clk);
      ext_count_pin = 1'b0;
    end
    repeat (10) @(negedge clk);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h00);
    rd_cmp(TCC_ADDR_CNT_LO, 5);
    set_cnt(16'hfff0);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h01);
    wait_hi(1'b0, 200);
    set_cnt(16'h0000);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h00);
    cpu.rd16(TCC_ADDR_CNT_LO, v);
    chk("wrapped", 16'h1, {15'h0, v < 16'h0040});
    m_cnt = v;
    repeat (20) @(posedge clk);
    rd_cmp(TCC_ADDR_CNT_LO, m_cnt);
    cpu.svc(1'b0);
    chk("ovf irq clear", 16'h0, {15'h0, overflow_irq});
    cpu.wr8(TCC_ADDR_FLAGS, 8'h01);
    cpu.wr8(TCC_ADDR_CTRL_A, 8'h01);
    set_cnt(16'h00f0);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h01);
    repeat (40) @(posedge clk);
    cpu.wr8(TCC_ADDR_CTRL_B, 8'h00);
    cpu.rd16(TCC_ADDR_CNT_LO, v);
    chk("down count", 16'h1, {15'h0, v >= 16'h00d0 && v < 16'h00f0});
    cpu.wr8(TCC_ADDR_IRQ_EN, 8'h00);
    report_and_stop();
  end
endmodule
